// File: enh_pkg.sv
package enh_pkg;
  // data path widths
  localparam int SAMPLE_W = 16;
  localparam int ACC_W    = 24;
  localparam int ADDR_W   = 16;
  localparam int DATA_W   = 32;
  localparam int BANDS    = 5;
  localparam int GAIN_W   = 5;
  localparam int SHIFT_W  = 4;
  localparam int GAIN_Q   = 12;
  localparam int ALPHA_Q  = 24;
  localparam int DELTA_W  = 17;

  // register word indices (avalon word address)
  localparam logic [ADDR_W-1:0] IDX_EQ_CTRL     = 16'h014f;
  localparam logic [ADDR_W-1:0] IDX_LEFT_LOWER  = 16'h0150;
  localparam logic [ADDR_W-1:0] IDX_LEFT_UPPER  = 16'h0151;
  localparam logic [ADDR_W-1:0] IDX_LEFT_COEF   = 16'h0152;
  localparam logic [ADDR_W-1:0] IDX_LEFT_LAST   = 16'h0163;
  localparam logic [ADDR_W-1:0] IDX_RIGHT_LOWER = 16'h0164;
  localparam logic [ADDR_W-1:0] IDX_RIGHT_UPPER = 16'h0165;
  localparam logic [ADDR_W-1:0] IDX_RIGHT_COEF  = 16'h0166;
  localparam logic [ADDR_W-1:0] IDX_RIGHT_LAST  = 16'h0177;
  localparam logic [ADDR_W-1:0] IDX_DRC_CTRL    = 16'h00f0;
  localparam logic [ADDR_W-1:0] IDX_STATUS      = 16'h00f1;
  localparam logic [ADDR_W-1:0] IDX_DSP_CTRL    = 16'h4004;
  localparam logic [ADDR_W-1:0] IDX_ENH_ENABLES = 16'h4005;
  localparam logic [ADDR_W-1:0] IDX_HPF_COEF_HI = 16'h4400;
  localparam logic [ADDR_W-1:0] IDX_HPF_COEF_LO = 16'h4401;

  // field positions
  localparam int GAIN_HI_LSB     = 11;
  localparam int FIELDS_PER_WORD = 3;
  localparam int COEF_USER_BIT   = 4;
  localparam int EQ_ON_BIT       = 0;
  localparam int COMMON_FLAG_BIT = 1;
  localparam int COMMON_SIDE_BIT = 2;
  localparam int DRC_ON_BIT      = 0;
  localparam int DRC_PATH_BIT    = 1;
  localparam int DSP_ON_BIT      = 0;
  localparam int HPF1_BIT        = 0;
  localparam int REC_FLAT_BIT    = 2;
  localparam int SURROUND_BIT    = 5;
  localparam int ENH_W           = 6;
  localparam int STATUS_W        = 6;
  localparam int ALPHA_HI_W      = 8;

  // reset values and codes
  localparam logic [GAIN_W-1:0] GAIN_RESET   = 5'h0c;
  localparam logic [GAIN_W-1:0] GAIN_TOP     = 5'h18;
  localparam logic [15:0]       GAIN_UNITY   = 16'h1000;
  localparam logic [15:0]       HPF_HI_RESET = 16'h0002;
  localparam logic [15:0]       HPF_LO_RESET = 16'h0000;

  // fixed band corners as first-order shifts, highest band first
  localparam logic [BANDS-1:0][SHIFT_W-1:0] FIXED_SHIFT = {4'h2, 4'h3, 4'h4, 4'h6, 4'h8};

  // noise gate
  localparam logic signed [ACC_W-1:0] GATE_LEVEL = 24'sh000040;
  localparam int                      GATE_SHIFT = 4;

  // linear gain per code, unity at 1 << GAIN_Q, -12 dB .. +12 dB
  localparam logic [15:0] GAIN_TAB [0:24] = '{
    16'h0405, 16'h0482, 16'h050f, 16'h05ad, 16'h065f, 16'h0726, 16'h0805, 16'h08ff,
    16'h0a18, 16'h0b54, 16'h0cb6, 16'h0e43, 16'h1000, 16'h11f4, 16'h1425, 16'h169a,
    16'h195c, 16'h1c74, 16'h1fed, 16'h23d2, 16'h2831, 16'h2d18, 16'h3299, 16'h38c5,
    16'h3fb2};
endpackage : enh_pkg

// File: pair_buffer.sv
`timescale 1ns/100ps
// two-entry skid buffer; ready is a flop so the source sees a clean stall
module pair_buffer #(
  parameter int WIDTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  typedef struct packed {
    logic             ready;
    logic             main_v;
    logic             skid_v;
    logic [WIDTH-1:0] main_d;
    logic [WIDTH-1:0] skid_d;
  } buf_state_t;

  buf_state_t q_r;
  buf_state_t q_nxt;

  // main entry drains first; skid only fills while main is held
  always_comb begin
    q_nxt = q_r;
    if (!q_r.main_v || out_ready) begin
      if (q_r.skid_v) begin
        q_nxt.main_v = 1'b1;
        q_nxt.main_d = q_r.skid_d;
        q_nxt.skid_v = 1'b0;
      end else begin
        q_nxt.main_v = in_valid && q_r.ready;
        if (in_valid && q_r.ready) begin
          q_nxt.main_d = in_data;
        end
      end
    end else if (in_valid && q_r.ready) begin
      q_nxt.skid_v = 1'b1;
      q_nxt.skid_d = in_data;
    end
    q_nxt.ready = !q_nxt.skid_v;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q_r       <= '0;
      q_r.ready <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign in_ready  = q_r.ready;
  assign out_valid = q_r.main_v;
  assign out_data  = q_r.main_d;
endmodule : pair_buffer

// File: dac_playback_enhancements.sv
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
// How it works
// R1: low highpass, high lowpass, middle notch bands; the code makes the middle bands bandpass
// R2: default mode uses fixed corners, gains programmable
// R3: fixed corners scale with sample rate
// R4: per band gain -12..+12 dB steps
// R5: gains reset to midpoint, top codes reserved
// R6: three gain fields per word, per channel
// R7: shared flag picks one side's settings
// R8: user band corners per channel register set
// R9: range controller on in one path only
// R10: path select one routes it to playback
// R11: noise gate attenuates very quiet input
// R12: two first-order highpass sections, own enables
// R13: processor enable set before highpass use
// R14: highpass needs another enhancement enable set
// R15: both highpass sections share one coefficient
// R16: equaliser acts only while enabled
// R17: disabled stages pass samples unchanged
module dac_playback_enhancements #(
  parameter int SAMPLE_W = enh_pkg::SAMPLE_W
) (
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  input  wire logic [enh_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [enh_pkg::DATA_W-1:0] avs_writedata,
  output logic      [enh_pkg::DATA_W-1:0] avs_readdata,
  output logic                            avs_waitrequest,
  input  wire logic                       in_valid,
  input  wire logic [SAMPLE_W-1:0]        in_left,
  input  wire logic [SAMPLE_W-1:0]        in_right,
  output logic                            in_ready,
  output logic                            out_valid,
  output logic      [SAMPLE_W-1:0]        out_left,
  output logic      [SAMPLE_W-1:0]        out_right,
  input  wire logic                       out_ready,
  output logic                            record_drc_on
);
  localparam int ACC_W = enh_pkg::ACC_W;
  localparam int BANDS = enh_pkg::BANDS;
  localparam int GW    = enh_pkg::GAIN_W;
  localparam logic signed [ACC_W-1:0] S_MAX = ACC_W'((1 << (SAMPLE_W - 1)) - 1);
  localparam logic signed [ACC_W-1:0] S_MIN = ~S_MAX;

  typedef struct packed {
    logic                                waitreq;
    logic [enh_pkg::DATA_W-1:0]          rdata;
    logic                                eq_on;
    logic                                common_flag;
    logic                                common_side;
    logic                                drc_on;
    logic                                drc_path;
    logic                                play_drc;
    logic                                rec_drc;
    logic                                dsp_on;
    logic [enh_pkg::ENH_W-1:0]           enh_en;
    logic [15:0]                         hpf_hi;
    logic [15:0]                         hpf_lo;
    logic [1:0][BANDS-1:0][GW-1:0]       gain;
    logic [1:0][BANDS-1:0][GW-1:0]       coef;
    logic [1:0][BANDS-1:0][ACC_W-1:0]    band_s;
    logic [1:0][1:0][ACC_W-1:0]          hpf_s;
  } enh_state_t;

  localparam enh_state_t RESET_STATE = '{
    waitreq: 1'b1,
    hpf_hi:  enh_pkg::HPF_HI_RESET,
    hpf_lo:  enh_pkg::HPF_LO_RESET,
    gain:    {(2 * BANDS){enh_pkg::GAIN_RESET}}, // R5
    default: '0
  };

  enh_state_t q_r;
  enh_state_t q_nxt;

  logic                                   take;
  logic [1:0]                             hpf_act;
  logic [1:0][BANDS-1:0][GW-1:0]          eff_gain;
  logic [1:0][BANDS-1:0][enh_pkg::SHIFT_W-1:0] eff_shift;
  logic signed [ACC_W-1:0]                x_in   [2];
  logic signed [ACC_W-1:0]                eq_y   [2];
  logic signed [ACC_W-1:0]                hpf_y  [2];
  logic signed [ACC_W-1:0]                drc_y  [2];
  logic [1:0][BANDS-1:0][ACC_W-1:0]       band_nxt;
  logic [1:0][1:0][ACC_W-1:0]             hpf_nxt;
  logic [1:0][SAMPLE_W-1:0]               y_out;
  logic                                   buf_out_valid;
  logic [2*SAMPLE_W-1:0]                  buf_out_data;

  // gain code to signed offset from unity; reserved codes clamp to the top step
  function automatic logic signed [enh_pkg::DELTA_W-1:0] gain_delta(input logic [GW-1:0] code);
    logic [GW-1:0] idx;
    idx = (code > enh_pkg::GAIN_TOP) ? enh_pkg::GAIN_TOP : code; // R5
    return $signed({1'b0, enh_pkg::GAIN_TAB[idx]}) - $signed({1'b0, enh_pkg::GAIN_UNITY}); // R4
  endfunction : gain_delta

  // gain word decode: {hit, channel, upper word}
  function automatic logic [2:0] gain_word(input logic [enh_pkg::ADDR_W-1:0] a);
    logic [2:0] r;
    r = 3'h0;
    case (a)
      enh_pkg::IDX_LEFT_LOWER:  r = 3'h4;
      enh_pkg::IDX_LEFT_UPPER:  r = 3'h5;
      enh_pkg::IDX_RIGHT_LOWER: r = 3'h6;
      enh_pkg::IDX_RIGHT_UPPER: r = 3'h7;
      default:                  r = 3'h0;
    endcase
    return r;
  endfunction : gain_word

  // user coefficient decode: {hit, channel, band}; only the first words of each range hold data
  function automatic logic [4:0] coef_slot(input logic [enh_pkg::ADDR_W-1:0] a);
    logic [4:0] r;
    r = 5'h00;
    if (a >= enh_pkg::IDX_LEFT_COEF && a < enh_pkg::IDX_LEFT_COEF + BANDS) begin
      r = {2'b10, 3'(a - enh_pkg::IDX_LEFT_COEF)};
    end else if (a >= enh_pkg::IDX_RIGHT_COEF && a < enh_pkg::IDX_RIGHT_COEF + BANDS) begin
      r = {2'b11, 3'(a - enh_pkg::IDX_RIGHT_COEF)};
    end
    return r;
  endfunction : coef_slot

  function automatic logic [SAMPLE_W-1:0] sat(input logic signed [ACC_W-1:0] v);
    if (v > S_MAX) begin
      return S_MAX[SAMPLE_W-1:0];
    end else if (v < S_MIN) begin
      return S_MIN[SAMPLE_W-1:0];
    end
    return v[SAMPLE_W-1:0];
  endfunction : sat

  assign take = in_valid && in_ready;

  // highpass only runs with the processor on and another enhancement enabled
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      hpf_act[k] = q_r.dsp_on && q_r.enh_en[enh_pkg::HPF1_BIT + k] // R13
                   && (|q_r.enh_en[enh_pkg::SURROUND_BIT:enh_pkg::REC_FLAT_BIT]); // R14
    end
  end

  // sample path: equaliser, two highpass sections, noise gate; all combinational so
  // latency is the same whether a stage is on or off
  always_comb begin : datapath
    logic                                   src;
    logic signed [ACC_W-1:0]                comp;
    logic signed [ACC_W-1:0]                acc;
    logic signed [ACC_W+enh_pkg::DELTA_W-1:0] prod;
    logic signed [ACC_W-1:0]                stage;
    logic signed [ACC_W-1:0]                diff;
    logic signed [2*ACC_W:0]                hprod;
    logic signed [ACC_W:0]                  alpha;
    src   = 1'b0;
    comp  = '0;
    acc   = '0;
    prod  = '0;
    stage = '0;
    diff  = '0;
    hprod = '0;
    alpha = $signed({1'b0, q_r.hpf_hi[enh_pkg::ALPHA_HI_W-1:0], q_r.hpf_lo}); // R15
    for (int c = 0; c < 2; c++) begin
      src = q_r.common_flag ? q_r.common_side : c[0]; // R7
      x_in[c] = ACC_W'($signed(c == 0 ? in_left : in_right));
      acc = '0;
      for (int b = 0; b < BANDS; b++) begin
        eff_gain[c][b] = q_r.gain[src][b];
        // fixed corners are fractions of the sample rate, so they track it
        eff_shift[c][b] = q_r.coef[src][b][enh_pkg::COEF_USER_BIT]
                          ? q_r.coef[src][b][enh_pkg::SHIFT_W-1:0] // R8
                          : enh_pkg::FIXED_SHIFT[b]; // R2 R3
        band_nxt[c][b] = ACC_W'($signed(q_r.band_s[c][b])
                         + ((x_in[c] - $signed(q_r.band_s[c][b])) >>> eff_shift[c][b]));
        if (b == 0) begin
          comp = x_in[c] - $signed(q_r.band_s[c][0]); // R1
        end else if (b == BANDS - 1) begin
          comp = $signed(q_r.band_s[c][b]); // R1
        end else begin
          comp = $signed(q_r.band_s[c][b]) - $signed(q_r.band_s[c][b-1]); // R1
        end
        prod = comp * gain_delta(eff_gain[c][b]); // R4
        acc  = acc + ACC_W'(prod >>> enh_pkg::GAIN_Q);
      end
      eq_y[c] = q_r.eq_on ? x_in[c] + acc : x_in[c]; // R16 R17
      stage = eq_y[c];
      // both sections use the shared coefficient; cascading gives second order
      for (int k = 0; k < 2; k++) begin
        diff  = stage - $signed(q_r.hpf_s[c][k]);
        hprod = diff * alpha;
        hpf_nxt[c][k] = hpf_act[k]
                        ? ACC_W'($signed(q_r.hpf_s[c][k]) + (hprod >>> enh_pkg::ALPHA_Q))
                        : q_r.hpf_s[c][k]; // R12
        stage = hpf_act[k] ? diff : stage; // R12 R17
      end
      hpf_y[c] = stage;
      drc_y[c] = (q_r.play_drc && stage < enh_pkg::GATE_LEVEL && stage > -enh_pkg::GATE_LEVEL)
                 ? (stage >>> enh_pkg::GATE_SHIFT) : stage; // R11 R17
      y_out[c] = sat(drc_y[c]);
    end
  end

  // register read mux
  function automatic logic [enh_pkg::DATA_W-1:0] reg_read(input enh_state_t s,
                                                          input logic [enh_pkg::ADDR_W-1:0] a,
                                                          input logic [enh_pkg::STATUS_W-1:0] st);
    logic [enh_pkg::DATA_W-1:0] r;
    logic [2:0]                 gw;
    logic [4:0]                 cs;
    int                         band;
    r  = '0;
    gw = gain_word(a);
    cs = coef_slot(a);
    band = 0;
    if (gw[2]) begin
      for (int k = 0; k < enh_pkg::FIELDS_PER_WORD; k++) begin
        band = (gw[0] ? enh_pkg::FIELDS_PER_WORD : 0) + k;
        if (band < BANDS) begin
          r[enh_pkg::GAIN_HI_LSB - GW*k +: GW] = s.gain[gw[1]][band]; // R6
        end
      end
    end else if (cs[4]) begin
      r[GW-1:0] = s.coef[cs[3]][cs[2:0]];
    end else begin
      case (a)
        enh_pkg::IDX_EQ_CTRL:     r[2:0] = {s.common_side, s.common_flag, s.eq_on};
        enh_pkg::IDX_DRC_CTRL:    r[1:0] = {s.drc_path, s.drc_on};
        enh_pkg::IDX_STATUS:      r[enh_pkg::STATUS_W-1:0] = st;
        enh_pkg::IDX_DSP_CTRL:    r[enh_pkg::DSP_ON_BIT] = s.dsp_on;
        enh_pkg::IDX_ENH_ENABLES: r[enh_pkg::ENH_W-1:0] = s.enh_en;
        enh_pkg::IDX_HPF_COEF_HI: r[15:0] = s.hpf_hi;
        enh_pkg::IDX_HPF_COEF_LO: r[15:0] = s.hpf_lo;
        default:                  r = '0;
      endcase
    end
    return r;
  endfunction : reg_read

  // bus, register writes and filter state; a request is answered one cycle after it is seen
  always_comb begin : next_state
    logic [2:0]           gw;
    logic [4:0]           cs;
    logic [GW-1:0]        fld;
    logic [15:0]          wd;
    int                   band;
    gw   = gain_word(avs_address);
    cs   = coef_slot(avs_address);
    wd   = avs_writedata[15:0];
    fld  = '0;
    band = 0;
    q_nxt = q_r;
    q_nxt.waitreq = !((avs_read || avs_write) && q_r.waitreq);
    if (avs_read && q_r.waitreq) begin
      q_nxt.rdata = reg_read(q_r, avs_address,
                             {buf_out_valid, hpf_act, q_r.rec_drc, q_r.play_drc, q_r.eq_on});
    end
    if (avs_write && !q_r.waitreq) begin
      if (gw[2]) begin
        for (int k = 0; k < enh_pkg::FIELDS_PER_WORD; k++) begin
          band = (gw[0] ? enh_pkg::FIELDS_PER_WORD : 0) + k;
          fld  = wd[enh_pkg::GAIN_HI_LSB - GW*k +: GW];
          if (band < BANDS) begin
            q_nxt.gain[gw[1]][band] = fld; // R6
          end
        end
      end else if (cs[4]) begin
        q_nxt.coef[cs[3]][cs[2:0]] = wd[GW-1:0]; // R8
      end else begin
        case (avs_address)
          enh_pkg::IDX_EQ_CTRL: begin
            q_nxt.eq_on       = wd[enh_pkg::EQ_ON_BIT];
            q_nxt.common_flag = wd[enh_pkg::COMMON_FLAG_BIT];
            q_nxt.common_side = wd[enh_pkg::COMMON_SIDE_BIT];
          end
          enh_pkg::IDX_DRC_CTRL: begin
            q_nxt.drc_on   = wd[enh_pkg::DRC_ON_BIT];
            q_nxt.drc_path = wd[enh_pkg::DRC_PATH_BIT];
          end
          enh_pkg::IDX_DSP_CTRL:    q_nxt.dsp_on = wd[enh_pkg::DSP_ON_BIT];
          enh_pkg::IDX_ENH_ENABLES: q_nxt.enh_en = wd[enh_pkg::ENH_W-1:0];
          enh_pkg::IDX_HPF_COEF_HI: q_nxt.hpf_hi = wd;
          enh_pkg::IDX_HPF_COEF_LO: q_nxt.hpf_lo = wd;
          default: ;
        endcase
      end
    end
    // one enable, one path: the two flags can never both be set
    q_nxt.play_drc = q_r.drc_on && q_r.drc_path; // R9 R10
    q_nxt.rec_drc  = q_r.drc_on && !q_r.drc_path; // R9
    if (take) begin
      q_nxt.band_s = band_nxt;
      q_nxt.hpf_s  = hpf_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q_r <= RESET_STATE;
    end else begin
      q_r <= q_nxt;
    end
  end

  // output buffer; its ready is the stall seen by the input side
  pair_buffer #(
    .WIDTH(2 * SAMPLE_W)
  ) u_out_buffer (
    .clk      (clk),
    .rst_b    (rst_b),
    .in_valid (in_valid),
    .in_data  ({y_out[0], y_out[1]}),
    .in_ready (in_ready),
    .out_valid(buf_out_valid),
    .out_data (buf_out_data),
    .out_ready(out_ready)
  );

  assign out_valid       = buf_out_valid;
  assign out_left        = buf_out_data[2*SAMPLE_W-1:SAMPLE_W];
  assign out_right       = buf_out_data[SAMPLE_W-1:0];
  assign avs_readdata    = q_r.rdata;
  assign avs_waitrequest = q_r.waitreq;
  assign record_drc_on   = q_r.rec_drc;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence bus_req_s;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence bus_ack_s;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  sequence right_lower_wr_s;
    avs_write && !avs_waitrequest && avs_address == enh_pkg::IDX_RIGHT_LOWER;
  endsequence

  bus_answer_a: assert property (bus_req_s |=> bus_ack_s)
    else $error("bus request not answered in one cycle");
  gain_pack_a: assert property (right_lower_wr_s |=> q_r.gain[1][1] == $past(avs_writedata[10:6])) // R6
    else $error("middle gain field not stored");
  common_gain_a: assert property (q_r.common_flag |-> eff_gain[0] == eff_gain[1]) // R7
    else $error("shared gains differ between channels");
  fixed_shift_a: assert property (!q_r.common_flag && !q_r.coef[0][0][enh_pkg::COEF_USER_BIT]
                                  |-> eff_shift[0][0] == enh_pkg::FIXED_SHIFT[0]) // R2
    else $error("fixed corner not used");
  user_coef_a: assert property (avs_write && !avs_waitrequest
                                && avs_address == enh_pkg::IDX_RIGHT_COEF + 16'h0002
                                |=> q_r.coef[1][2] == $past(avs_writedata[4:0])) // R8
    else $error("user coefficient not stored");
  eq_bypass_a: assert property (!q_r.eq_on |-> eq_y[1] == x_in[1]) // R16
    else $error("equaliser altered samples while off");
  stage_bypass_a: assert property (!q_r.eq_on && hpf_act == 2'b00 && !q_r.play_drc
                                   |-> y_out[0] == in_left) // R17
    else $error("disabled stages altered samples");
  drc_one_path_a: assert property (!(record_drc_on && q_r.play_drc)) // R9
    else $error("range controller in both paths");
  drc_route_a: assert property (q_r.drc_on && q_r.drc_path |=> q_r.play_drc && !record_drc_on) // R10
    else $error("range controller not routed to playback");
  gate_a: assert property (q_r.play_drc && hpf_y[0] < enh_pkg::GATE_LEVEL
                           && hpf_y[0] > -enh_pkg::GATE_LEVEL
                           |-> drc_y[0] == (hpf_y[0] >>> enh_pkg::GATE_SHIFT)) // R11
    else $error("noise gate did not attenuate");
  hpf_guard_a: assert property (!q_r.dsp_on |-> hpf_act == 2'b00) // R13
    else $error("highpass active without processor enable");
  hpf_hold_a: assert property (!hpf_act[0] |=> $stable(q_r.hpf_s[0][0])) // R12
    else $error("idle highpass section changed state");
endmodule : dac_playback_enhancements

// File: stream_sink.sv
`timescale 1ns/100ps
// downstream sink model: takes a pair whenever ready, stalls on request
module stream_sink (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic hold_off,
  output logic      out_ready
);
  // ready is registered, so a stall always starts on a clean edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) out_ready <= 1'b0;
    else out_ready <= !hold_off;
  end
endmodule : stream_sink

// File: dac_playback_enhancements_tb_top.sv
`timescale 1ns/100ps
module dac_playback_enhancements_tb_top;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [15:0] avs_address = 16'h0000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest, in_ready, out_valid, out_ready, record_drc_on;
  logic        in_valid = 1'b0;
  logic [15:0] in_left = 16'h0, in_right = 16'h0, out_left, out_right, d;
  logic        hold_off = 1'b0, force_stall = 1'b0, rnd_stall = 1'b0, saw_full = 1'b0;
  logic [31:0] seed = 32'h45, tmp, tick;
  logic [31:0] reg_q[$], pair_q[$];
  int          fails = 0, tests_run = 0, cycles = 0;
  logic [15:0] ra [8] = '{enh_pkg::IDX_LEFT_LOWER, enh_pkg::IDX_LEFT_UPPER,
    enh_pkg::IDX_RIGHT_LOWER, enh_pkg::IDX_RIGHT_UPPER, enh_pkg::IDX_HPF_COEF_HI,
    enh_pkg::IDX_HPF_COEF_LO, enh_pkg::IDX_DRC_CTRL, 16'h0200};
  logic [15:0] rv [8] = '{16'h6318, 16'h6300, 16'h6318, 16'h6300, 16'h0002, 16'h0000,
    16'h0000, 16'h0000};

  // 40 MHz clock
  always #12.5 clk = ~clk;

  dac_playback_enhancements i_dac_playback_enhancements (
    .clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .in_valid(in_valid), .in_left(in_left),
    .in_right(in_right), .in_ready(in_ready), .out_valid(out_valid), .out_left(out_left),
    .out_right(out_right), .out_ready(out_ready), .record_drc_on(record_drc_on));

  stream_sink i_stream_sink (.clk(clk), .rst_b(rst_b), .hold_off(hold_off),
    .out_ready(out_ready));

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_pair(input logic [31:0] got, input logic [31:0] exp);
    check_word(got, exp);
  endtask : check_pair

  task automatic check_flag(input logic got, input logic exp);
    check_word({31'h0, got}, {31'h0, exp});
  endtask : check_flag

  task automatic tally_and_finish();
    if (fails == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  // one bus cycle; request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [15:0] a, input logic [15:0] v);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {16'h0, v};
    avs_read <= !wr;
    avs_write <= wr;
    // no local limit: only the bench watchdog ends a hung access
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic bus_read(input logic [15:0] a, input logic [15:0] e);
    reg_q.push_back({16'h0, e});
    bus(1'b0, a, 16'h0);
  endtask : bus_read

  // back-to-back pairs; gated ones are small multiples of 16, so the shift is exact
  task automatic burst(input int cnt, input logic gate);
    logic [15:0] l, r;
    int n;
    for (int i = 0; i < cnt; i++) begin
      tmp = rnd();
      l = tmp[0] ? 16'h0 - {10'h0, tmp[2:1], 4'h0} : {10'h0, tmp[2:1], 4'h0};
      r = tmp[3] ? 16'h0 - {10'h0, tmp[5:4], 4'h0} : {10'h0, tmp[5:4], 4'h0};
      if (!gate) {l, r} = tmp;
      in_valid <= 1'b1;
      in_left <= l;
      in_right <= r;
      pair_q.push_back(gate ? {16'($signed(l) >>> 4), 16'($signed(r) >>> 4)} : {l, r});
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (in_ready !== 1'b1 && n < 200);
    end
    in_valid <= 1'b0;
    n = 0;
    while (pair_q.size() > 0 && n < 200) begin
      @(posedge clk);
      n++;
    end
    check_flag(pair_q.size() == 0, 1'b1);
  endtask : burst

  // result watcher, sink stall pattern and hang guard
  always @(posedge clk) begin
    tick = rnd();
    hold_off <= force_stall | (rnd_stall & tick[0]);
    if (avs_read && avs_waitrequest === 1'b0 && reg_q.size() > 0)
      check_word(avs_readdata, reg_q.pop_front());
    if (out_valid === 1'b1 && out_ready === 1'b1)
      check_pair({out_left, out_right}, pair_q.size() > 0 ? pair_q.pop_front() : 32'hx);
    if (in_valid && in_ready === 1'b0) saw_full <= 1'b1;
    cycles++;
    if (cycles > 20000) begin
      fails++;
      tally_and_finish();
    end
  end

  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 8; i++) bus_read(ra[i], rv[i]);
    tmp = rnd();
    d = {5'(tmp[7:0] % 25), 5'(tmp[15:8] % 25), 5'(tmp[23:16] % 25), 1'b0};
    bus(1'b1, enh_pkg::IDX_LEFT_UPPER, d);
    bus_read(enh_pkg::IDX_LEFT_UPPER, d & 16'hffc0);
    bus(1'b1, enh_pkg::IDX_RIGHT_LOWER, d);
    bus_read(enh_pkg::IDX_RIGHT_LOWER, d);
    bus(1'b1, enh_pkg::IDX_RIGHT_COEF + 16'h0002, 16'h0013);
    bus_read(enh_pkg::IDX_RIGHT_COEF + 16'h0002, 16'h0013);
    bus(1'b1, 16'h0200, 16'hffff);
    bus_read(16'h0200, 16'h0000);
    bus(1'b1, enh_pkg::IDX_EQ_CTRL, 16'h0007);
    bus_read(enh_pkg::IDX_EQ_CTRL, 16'h0007);
    bus_read(enh_pkg::IDX_STATUS, 16'h0001);
    bus(1'b1, enh_pkg::IDX_EQ_CTRL, 16'h0000);
    force_stall <= 1'b1;
    fork
      burst(8, 1'b0);
      begin
        repeat (12) @(posedge clk);
        force_stall <= 1'b0;
      end
    join
    check_flag(saw_full, 1'b1);
    rnd_stall <= 1'b1;
    burst(24, 1'b0);
    bus(1'b1, enh_pkg::IDX_DSP_CTRL, 16'h0001);
    bus(1'b1, enh_pkg::IDX_ENH_ENABLES, 16'h0003);
    bus_read(enh_pkg::IDX_STATUS, 16'h0000);
    bus(1'b1, enh_pkg::IDX_ENH_ENABLES, 16'h0023);
    bus_read(enh_pkg::IDX_STATUS, 16'h0018);
    bus(1'b1, enh_pkg::IDX_ENH_ENABLES, 16'h0000);
    bus(1'b1, enh_pkg::IDX_DRC_CTRL, 16'h0001);
    repeat (2) @(posedge clk);
    check_flag(record_drc_on, 1'b1);
    bus_read(enh_pkg::IDX_STATUS, 16'h0004);
    bus(1'b1, enh_pkg::IDX_DRC_CTRL, 16'h0003);
    repeat (2) @(posedge clk);
    check_flag(record_drc_on, 1'b0);
    bus_read(enh_pkg::IDX_STATUS, 16'h0002);
    burst(8, 1'b1);
    bus(1'b1, enh_pkg::IDX_DRC_CTRL, 16'h0000);
    burst(8, 1'b0);
    tally_and_finish();
  end
endmodule : dac_playback_enhancements_tb_top
